// File: hdl/sem_host.sv
`timescale 1ns/1ns
`default_nettype none
module sem_host
  import sem_host_pkg::*;
#(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output port_ctl_t PORT_CTL,
  output logic [DW-1:0] DQ_O,
  output logic DQ_OE_N,
  input wire logic [DW-1:0] DQ_I,
  output logic ROLE_MASTER,
  output logic BUSY_O,
  output logic BUSY_OE_N,
  input wire logic BUSY_I_N
);
  // ============================================================
  // registers
  state_t state, next_state;
  port_ctl_t ctl, next_ctl;
  logic [DW-1:0] dout, next_dout;
  logic dq_oe_n, next_dq_oe_n;
  logic [DW-1:0] rdata, next_rdata;
  logic [31:0] cmd, next_cmd;
  logic [31:0] cfg, next_cfg;
  logic [7:0] cnt, next_cnt;
  logic [7:0] polls, next_polls;
  logic [2:0] step, next_step;
  logic busy, next_busy;
  logic owned, next_owned;
  logic failed, next_failed;
  logic busy_seen, next_busy_seen;
  logic done_evt, next_done_evt;

  op_t op;
  logic [2:0] sem_idx;
  logic wr_en;
  logic rd_en;

  assign op = op_t'(cmd[CMD_KIND_LSB +: 3]);
  assign sem_idx = cmd[CMD_SEM_LSB +: 3] & SEM_ADDR_MASK;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;

  // ============================================================
  // apb slave: zero wait states
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  always_comb begin
    case (PADDR)
      REG_CMD: PRDATA = cmd;
      REG_STATUS: PRDATA = {26'h0, done_evt, busy_seen, failed, owned,
                            1'b0, busy};
      REG_RDATA: PRDATA = {{(32-DW){1'b0}}, rdata};
      REG_CFG: PRDATA = cfg;
      default: PRDATA = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // pins
  assign PORT_CTL = ctl;
  assign DQ_O = dout;
  assign DQ_OE_N = dq_oe_n;
  assign ROLE_MASTER = cfg[CFG_MASTER];
  // host never drives busy; slave systems keep it high
  assign BUSY_O = 1'b1;
  assign BUSY_OE_N = 1'b1;

  // ============================================================
  // sequencer
  always_comb begin
    next_state = state;
    next_ctl = ctl;
    next_dout = dout;
    next_dq_oe_n = dq_oe_n;
    next_rdata = rdata;
    next_cmd = cmd;
    next_cfg = cfg;
    next_cnt = cnt;
    next_polls = polls;
    next_step = step;
    next_busy = busy;
    next_owned = owned;
    next_failed = failed;
    next_busy_seen = busy_seen;
    next_done_evt = done_evt;
    if (rd_en && PADDR == REG_STATUS) begin
      next_done_evt = 1'b0;
      next_busy_seen = 1'b0;
    end
    if (wr_en && PADDR == REG_CFG) begin
      next_cfg = PWDATA;
    end
    case (state)
      ST_IDLE: begin
        next_ctl.ce_n = 1'b1;
        next_ctl.flag_space_select_n = 1'b1;
        next_ctl.oe_n = 1'b1;
        next_ctl.rw_n = 1'b1;
        next_dq_oe_n = 1'b1;
        if (wr_en && PADDR == REG_CMD && PWDATA[CMD_GO]) begin
          next_cmd = PWDATA;
          next_busy = 1'b1;
          next_failed = 1'b0;
          next_polls = 8'h00;
          next_step = 3'h0;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_cnt = SETTLE_CNT;
        next_ctl.rw_n = 1'b1;
        next_ctl.oe_n = 1'b1;
        if (op == OP_MEM_RD || op == OP_MEM_WR) begin
          next_ctl.ce_n = 1'b0;
          next_ctl.addr = cmd[CMD_ADDR_LSB +: AW];
        end else begin
          next_ctl.flag_space_select_n = 1'b0;
          next_ctl.addr = {{(AW-3){1'b0}}, sem_idx};
        end
        // take: write 0 then read back; release: write 1; init: 1
        if (op == OP_MEM_WR) begin
          next_dout = cmd[CMD_DATA_LSB +: DW];
          next_state = ST_WRITE;
        end else if (op == OP_SEM_TAKE && step == 3'h0) begin
          next_dout = {DW{1'b0}};
          next_state = ST_WRITE;
        end else if ((op == OP_SEM_REL || op == OP_SEM_INIT)
                     && step == 3'h0) begin
          next_dout = {{(DW-1){1'b0}}, 1'b1};
          next_state = ST_WRITE;
        end else begin
          next_state = ST_READ;
        end
      end
      ST_WRITE: begin
        if (step == 3'h0) begin
          // address settles before the write strobe
          if (cnt > 8'h01) begin
            next_cnt = cnt - 8'h01;
          end else begin
            next_ctl.rw_n = 1'b0;
            next_dq_oe_n = 1'b0;
            next_cnt = PULSE_CNT - 8'h01;
            next_step = 3'h1;
          end
        end else begin
          // busy input is the ANDed busy of the whole array
          if (!BUSY_I_N) begin
            next_busy_seen = 1'b1;
          end
          if (cnt != 8'h00) begin
            next_cnt = cnt - 8'h01;
          end else begin
            next_ctl.rw_n = 1'b1;
            next_dq_oe_n = 1'b1;
            next_state = ST_GAP;
          end
        end
      end
      ST_READ: begin
        next_ctl.oe_n = 1'b0;
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else begin
          next_rdata = DQ_I;
          next_state = ST_GAP;
          if (op == OP_SEM_TAKE || op == OP_SEM_RD) begin
            next_owned = !DQ_I[0];
          end
        end
      end
      ST_GAP: begin
        // drop select and enable so the next read recaptures
        next_ctl.oe_n = 1'b1;
        next_ctl.ce_n = 1'b1;
        next_ctl.flag_space_select_n = 1'b1;
        next_state = ST_DONE;
        if (op == OP_SEM_TAKE && step == 3'h1) begin
          next_step = 3'h2;
          next_state = ST_SETUP;
        end else if (op == OP_SEM_TAKE && step == 3'h2 && !owned) begin
          if (polls < cfg[CFG_POLLMAX_LSB +: 8]) begin
            next_polls = polls + 8'h01;
            next_state = ST_SETUP;
          end else begin
            // withdraw the pending request
            next_failed = 1'b1;
            next_step = 3'h0;
            next_cmd[CMD_KIND_LSB +: 3] = OP_SEM_REL;
            next_state = ST_SETUP;
          end
        end else if (op == OP_SEM_INIT && step == 3'h1
                     && sem_idx != 3'h7) begin
          next_cmd[CMD_SEM_LSB +: 3] = sem_idx + 3'h1;
          next_step = 3'h0;
          next_state = ST_SETUP;
        end
      end
      ST_DONE: begin
        if (op == OP_SEM_REL || op == OP_SEM_INIT) begin
          next_owned = 1'b0;
        end
        next_busy = 1'b0;
        next_done_evt = 1'b1;
        next_cmd[CMD_GO] = 1'b0;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      ctl <= '{ce_n: 1'b1, flag_space_select_n: 1'b1, oe_n: 1'b1,
               rw_n: 1'b1, addr: 13'h0000};
      dout <= '0;
      dq_oe_n <= 1'b1;
      rdata <= '0;
      cmd <= 32'h0000_0000;
      cfg <= CFG_RESET;
      cnt <= 8'h00;
      polls <= 8'h00;
      step <= 3'h0;
      busy <= 1'b0;
      owned <= 1'b0;
      failed <= 1'b0;
      busy_seen <= 1'b0;
      done_evt <= 1'b0;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
      dout <= next_dout;
      dq_oe_n <= next_dq_oe_n;
      rdata <= next_rdata;
      cmd <= next_cmd;
      cfg <= next_cfg;
      cnt <= next_cnt;
      polls <= next_polls;
      step <= next_step;
      busy <= next_busy;
      owned <= next_owned;
      failed <= next_failed;
      busy_seen <= next_busy_seen;
      done_evt <= next_done_evt;
    end
  end
endmodule : sem_host
`default_nettype wire

// File: hdl/sem_host_pkg.sv
// Contract
// - slave system holds both busy pins high
// - depth cascade ANDs busy outputs externally
// - width cascade uses exactly one master
// - address and select settle before write pulse
// - flag select low, normal memory signalling
// - write zero requests, write one releases
// - poller drops select or enable between reads
// - requester writes, reads back, then decides
package sem_host_pkg;
  // ============================================================
  // register map
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RDATA = 12'h008;
  localparam logic [11:0] REG_CFG = 12'h00C;
  // cmd fields
  localparam int CMD_GO = 31;
  localparam int CMD_KIND_LSB = 28;
  localparam int CMD_SEM_LSB = 24;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 0;
  // cfg fields
  localparam int CFG_MASTER = 0;
  localparam int CFG_POLLMAX_LSB = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_1001;
  // ============================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_NS = 30;
  localparam int PULSE_NS = 40;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYC);
  localparam logic [7:0] PULSE_CNT = 8'(PULSE_CYC);
  localparam logic [2:0] SEM_ADDR_MASK = 3'h7;

  typedef enum logic [2:0] {
    OP_MEM_RD = 3'h0,
    OP_MEM_WR = 3'h1,
    OP_SEM_RD = 3'h2,
    OP_SEM_REL = 3'h3,
    OP_SEM_TAKE = 3'h4,
    OP_SEM_INIT = 3'h5
  } op_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_WRITE = 6'b000100,
    ST_READ = 6'b001000,
    ST_GAP = 6'b010000,
    ST_DONE = 6'b100000
  } state_t;

  typedef struct packed {
    logic ce_n;
    logic flag_space_select_n;
    logic oe_n;
    logic rw_n;
    logic [12:0] addr;
  } port_ctl_t;
endpackage : sem_host_pkg

// File: tb/sem_host_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sem_host_asserts
  import sem_host_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire port_ctl_t PORT_CTL,
  input wire logic [DW-1:0] DQ_O,
  input wire logic DQ_OE_N,
  input wire logic ROLE_MASTER,
  input wire logic BUSY_OE_N
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ==========
  // device port strobes
  sequence s_pulse;
    !PORT_CTL.rw_n [*4] ##1 PORT_CTL.rw_n;
  endsequence
  sequence s_sel_early;
    $past(!PORT_CTL.ce_n || !PORT_CTL.flag_space_select_n, 2);
  endsequence
  a_pulse_len: assert property ($fell(PORT_CTL.rw_n) |-> s_pulse)
    else $error("write pulse length wrong");
  a_settle_first: assert property ($fell(PORT_CTL.rw_n) |-> s_sel_early)
    else $error("write pulse before select settled");
  a_write_steady: assert property (!PORT_CTL.rw_n && $past(!PORT_CTL.rw_n)
    |-> $stable(PORT_CTL.addr) && $stable(DQ_O))
    else $error("address or data moved in write pulse");
  a_write_drives: assert property (!PORT_CTL.rw_n |-> !DQ_OE_N
    && (!PORT_CTL.ce_n || !PORT_CTL.flag_space_select_n))
    else $error("write without select or data drive");
  a_read_quiet: assert property (!PORT_CTL.oe_n |-> DQ_OE_N && PORT_CTL.rw_n)
    else $error("read while driving data");
  a_one_space: assert property (PORT_CTL.ce_n || PORT_CTL.flag_space_select_n)
    else $error("both spaces selected");
  a_busy_undriven: assert property (BUSY_OE_N)
    else $error("host drives busy");
  a_role_write: assert property ($changed(ROLE_MASTER)
    |-> $past(PSEL && PENABLE && PWRITE && PADDR == REG_CFG))
    else $error("role changed without config write");
endmodule : sem_host_asserts
bind sem_host sem_host_asserts #(.DW(DW)) u_chk (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PORT_CTL(PORT_CTL), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N),
  .ROLE_MASTER(ROLE_MASTER), .BUSY_OE_N(BUSY_OE_N)
);
`default_nettype wire

// File: tb/sem_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module sem_dev_model
  import sem_host_pkg::*;
(
  input wire port_ctl_t ctl,
  input wire logic [7:0] din,
  input wire logic far_sel,
  input wire logic [12:0] far_addr,
  input wire logic [7:0] far_req,
  output logic busy_n,
  output logic [7:0] dout
);
  logic [7:0] mem [0:8191];
  logic [7:0] own = 8'h00;
  logic [7:0] pend = 8'h00;
  logic [7:0] hold = 8'hFF;
  wire [2:0] i = ctl.addr[2:0];
  // far port selected first keeps the cell; only this side is busied
  assign busy_n = !(far_sel && !ctl.ce_n
    && ctl.addr == far_addr);
  initial dout = 8'h3C;
  // ==========
  // write at end of pulse
  always @(posedge ctl.rw_n) begin
    if (!ctl.flag_space_select_n) begin
      if (!din[0]) begin
        if (!far_req[i]) own[i] = 1'b1;
        else pend[i] = 1'b1;
      end else begin
        own[i] = 1'b0;
        pend[i] = 1'b0;
      end
    end else if (!ctl.ce_n && busy_n) begin
      mem[ctl.addr] = din;
    end
  end
  // far side frees its token, pending request takes it
  always @(far_req) begin
    own = own | (pend & ~far_req);
    pend = pend & far_req;
  end
  always @(negedge (ctl.flag_space_select_n | ctl.oe_n)) begin
    hold = {8{~own[i]}};
  end
  always @(ctl or hold) begin
    if (!ctl.oe_n && ctl.rw_n) begin
      dout = !ctl.flag_space_select_n ? hold : mem[ctl.addr];
    end else begin
      dout = ~dout;
    end
  end
endmodule : sem_dev_model
`default_nettype wire

// File: tb/test_sem_host.sv
`timescale 1ns/1ns
`default_nettype none
module test_sem_host;
  import sem_host_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, far_sel = 0;
  logic busy_n;
  logic [12:0] far_addr = 13'h1ABC;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic pready, dq_oe_n, role_master, pslverr, busy_o, busy_oe_n;
  logic [7:0] dq_o, dq_i, far_req = 8'h00;
  port_ctl_t ctl;
  int fail_count = 0, check_count = 0;
  always #5 clk = ~clk;
  sem_host dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PORT_CTL(ctl), .DQ_O(dq_o),
    .DQ_OE_N(dq_oe_n), .DQ_I(dq_i), .ROLE_MASTER(role_master),
    .BUSY_O(busy_o), .BUSY_OE_N(busy_oe_n), .BUSY_I_N(busy_n));
  sem_dev_model dev (.ctl(ctl), .din(dq_o), .far_sel(far_sel),
    .far_addr(far_addr), .far_req(far_req), .busy_n(busy_n), .dout(dq_i));
  // ==========
  // bus and check tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    chk("slave error", {31'h0, pslverr}, 32'h0);
    psel <= 0;
    penable <= 0;
    if (n == 50) begin
      fail_count++;
      end_sim();
    end
  endtask : apb
  function automatic logic [31:0] mk(input logic [2:0] k, s,
    input logic [12:0] a, input logic [7:0] d);
    return {1'b1, k, 1'b0, s, 3'h0, a, d};
  endfunction : mk
  task automatic op(input logic [31:0] c, output logic [31:0] s);
    int n;
    logic [31:0] acc;
    acc = 32'h0;
    apb(1, REG_CMD, c, s);
    for (n = 0; n < 300; n++) begin
      apb(0, REG_STATUS, 32'h0, s);
      acc = acc | s;
      if (s[0] === 1'b0) break;
    end
    // clear-on-read bits gathered over all polls
    s = {s[31:6], acc[5:4], s[3:0]};
    if (n == 300) begin
      fail_count++;
      end_sim();
    end
  endtask : op
  task automatic sem_rd(input logic [2:0] s, input logic [31:0] exp);
    op(mk(OP_SEM_RD, s, 13'h1FF8, 8'h00), st);
    apb(0, REG_RDATA, 32'h0, rd);
    chk("sem read", rd, exp);
  endtask : sem_rd
  // ==========
  // sequence of tests
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    apb(0, REG_CFG, 32'h0, rd);
    chk("cfg reset", rd, CFG_RESET);
    chk("role", {31'h0, role_master}, 32'h1);
    chk("busy pin", {30'h0, busy_o, busy_oe_n}, 32'h3);
    apb(0, 12'h010, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    op(mk(OP_MEM_WR, 3'h0, 13'h1ABC, 8'h5A), st);
    chk("wr status", st & 32'h3F, 32'h20);
    far_sel <= 1;
    op(mk(OP_MEM_WR, 3'h0, 13'h1ABC, 8'h33), st);
    chk("busy seen", st & 32'h30, 32'h30);
    far_sel <= 0;
    op(mk(OP_MEM_RD, 3'h0, 13'h1ABC, 8'h00), st);
    apb(0, REG_RDATA, 32'h0, rd);
    chk("mem read", rd, 32'h5A);
    $display("memory test done");
    op(mk(OP_SEM_INIT, 3'h0, 13'h0, 8'h00), st);
    for (int s = 0; s < 8; s++) begin
      op(mk(OP_SEM_TAKE, 3'(s), 13'h1FF8, 8'h00), st);
      chk("take", st & 32'hC, 32'h4);
      sem_rd(3'(s), 32'h00);
      op(mk(OP_SEM_REL, 3'(s), 13'h1FF8, 8'h00), st);
      sem_rd(3'(s), 32'h0000_00FF);
    end
    $display("semaphore test done");
    apb(1, REG_CFG, 32'h0000_0200, rd);
    @(posedge clk);
    chk("slave role", {31'h0, role_master}, 32'h0);
    far_req <= 8'h20;
    op(mk(OP_SEM_TAKE, 3'h5, 13'h0005, 8'h00), st);
    chk("take fails", st & 32'hC, 32'h8);
    far_req <= 8'h00;
    sem_rd(3'h5, 32'h0000_00FF);
    $display("contention test done");
    end_sim();
  end
endmodule : test_sem_host
`default_nettype wire
